// file: dv/ifch_host.sv
// Purpose: Host bridge model issuing config and I/O cycles
// Assumes: One request in flight; answer comes one cycle after take
// Notes:   Released lines carry inverted last value, not stale data
`timescale 1ns/1ps
`default_nettype none
module ifch_host
  import ifch_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire ifch_pkg::ifch_cfg_rsp_s cfg_out,
  input  wire ifch_pkg::ifch_io_rsp_s  io_out,
  output ifch_pkg::ifch_cfg_req_s      cfg_in,
  output logic                         io_req,
  output logic [15:0]                  io_addr
);
  initial begin
    cfg_in  = '0;
    io_req  = 1'b0;
    io_addr = 16'h0000;
  end
  task automatic cfg(input logic w, input logic [5:0] d, input logic [3:0] b, input logic [31:0] v,
                     output logic [32:0] rsp);
    @(posedge sys_clk);
    cfg_in <= '{req: 1'b1, wr: w, dw: d, be: b, wdata: v};
    @(posedge sys_clk);
    cfg_in <= '{req: 1'b0, wr: ~w, dw: ~d, be: ~b, wdata: ~v};
    @(negedge sys_clk);
    rsp = {cfg_out.ack, cfg_out.rdata};
  endtask
  task automatic io(input logic [15:0] a, output logic [5:0] rsp);
    @(posedge sys_clk);
    io_req  <= 1'b1;
    io_addr <= a;
    @(posedge sys_clk);
    io_req  <= 1'b0;
    io_addr <= ~a;
    @(negedge sys_clk);
    rsp = {io_out.done, io_out.refused, io_out.hit};
  endtask
endmodule // ifch_host
`default_nettype wire

// file: dv/ifch_top_asserts.sv
// Purpose: Port-level checks of the configuration header bank
// Assumes: One clock domain, reset disables every check
// Notes:   Read checks look at the answer one cycle after take
`timescale 1ns/1ps
`default_nettype none
module ifch_top_asserts
  import ifch_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    clk_en,
  input wire ifch_pkg::ifch_cfg_req_s cfg_in,
  input wire ifch_pkg::ifch_cfg_rsp_s cfg_out,
  input wire logic                    io_space_enable,
  input wire logic                    master_abort_evt,
  input wire logic                    target_abort_evt,
  input wire logic                    io_req,
  input wire logic [15:0]             io_addr,
  input wire logic                    bm_io_hit,
  input wire ifch_pkg::ifch_io_rsp_s  io_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic rd  = cfg_in.req && clk_en && !cfg_in.wr;
  wire logic ior = io_req && clk_en;
  AST_STS_FIXED: assert property (rd && cfg_in.dw == 6'h01 |=> cfg_out.ack &&
    cfg_out.rdata[31:30] == 2'b00 && !cfg_out.rdata[28] && cfg_out.rdata[26:16] == 11'h280)
    else $error("status fixed bits wrong");
  AST_RMA_SET: assert property (master_abort_evt && clk_en ##1 rd && cfg_in.dw == 6'h01
    |=> cfg_out.rdata[29]) else $error("master abort flag not set");
  AST_STA_SET: assert property (target_abort_evt && clk_en ##1 rd && cfg_in.dw == 6'h01
    |=> cfg_out.rdata[27]) else $error("target abort flag not set");
  AST_ID_FIXED: assert property (rd && cfg_in.dw == 6'h02 |=> cfg_out.rdata[31:16] == 16'h0101 &&
    (cfg_out.rdata[15:8] & 8'hfa) == 8'h8a) else $error("class or interface bits wrong");
  AST_MLT_ZERO: assert property (rd && cfg_in.dw == 6'h03 |=> cfg_out.rdata[15:8] == 8'h00)
    else $error("latency timer not zero");
  AST_BAR_FIXED: assert property (rd && cfg_in.dw[5:2] == 4'h1 |=> cfg_out.rdata[31:16] == 16'h0000 &&
    cfg_out.rdata[1:0] == 2'b01) else $error("base register fixed bits wrong");
  AST_MODE_SEL: assert property (cfg_in.req && clk_en && cfg_in.wr && cfg_in.dw == 6'h02 && cfg_in.be[1]
    |=> io_out.native == {$past(cfg_in.wdata[10]), $past(cfg_in.wdata[8])}) else $error("mode select wrong");
  AST_IO_OFF: assert property (ior && !io_space_enable |=> io_out.done && io_out.hit == 4'h0)
    else $error("claim while io space off");
  AST_BM_REFUSED: assert property (ior && !io_space_enable && bm_io_hit |=> io_out.refused)
    else $error("bus master access not refused");
  AST_NATIVE_ONLY: assert property (ior && io_out.native == 2'b00 && io_addr >= 16'h0400
    |=> io_out.hit == 4'h0) else $error("native window claimed in legacy mode");
endmodule // ifch_top_asserts
bind ifch_top ifch_top_asserts chk_i (.sys_clk, .reset, .clk_en, .cfg_in, .cfg_out, .io_space_enable,
  .master_abort_evt, .target_abort_evt, .io_req, .io_addr, .bm_io_hit, .io_out);
`default_nettype wire

// file: dv/tb.sv
// Purpose: Register and decode tests of the configuration header bank
// Assumes: Clock enable dropped once to show a frozen write; host model drives requests
// Notes:   Bases placed before native mode and I/O enable
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ifch_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, io_space_enable = 1'b0;
  logic master_abort_evt = 1'b0, target_abort_evt = 1'b0, bm_io_hit = 1'b0, io_req;
  logic [15:0] io_addr;
  ifch_cfg_req_s cfg_in;
  ifch_cfg_rsp_s cfg_out;
  ifch_io_rsp_s  io_out;
  int err_count = 0, checked = 0, cyc = 0;
  logic [32:0] r;
  logic [5:0]  s;
  always #10 sys_clk = ~sys_clk;
  ifch_top dut (.sys_clk, .reset, .clk_en, .cfg_in, .cfg_out, .io_space_enable, .master_abort_evt,
    .target_abort_evt, .io_req, .io_addr, .bm_io_hit, .io_out);
  ifch_host host (.sys_clk, .cfg_out, .io_out, .cfg_in, .io_req, .io_addr);
  // Events last one cycle; cleared only when set, so no same-step clash
  always @(posedge sys_clk) if (master_abort_evt) master_abort_evt <= 1'b0;
  always @(posedge sys_clk) if (target_abort_evt) target_abort_evt <= 1'b0;
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [5:0] d, input logic [31:0] e);
    host.cfg(1'b0, d, 4'h0, 32'h0, r);
    chk(r, {1'b1, e});
  endtask
  task wr(input logic [5:0] d, input logic [3:0] b, input logic [31:0] v);
    host.cfg(1'b1, d, b, v, r);
  endtask
  task ic(input logic [15:0] a, input logic [5:0] e);
    host.io(a, s);
    chk({27'h0, s}, {27'h0, e});
  endtask
  task results;
    $display("Checks made %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rc(6'h01, 32'h02800000);
    rc(6'h02, 32'h01018a00);
    for (int i = 4; i < 8; i++) rc(i[5:0], 32'h00000001);
    wr(6'h01, 4'hf, 32'hffffffff);
    rc(6'h01, 32'h02800000);
    host.cfg(1'b0, 6'h03, 4'h0, 32'h0, r);
    chk({r[32], 24'h0, r[15:8]}, {1'b1, 32'h0});
    wr(6'h03, 4'hf, 32'hffffffff);
    host.cfg(1'b0, 6'h03, 4'h0, 32'h0, r);
    chk({r[32], 24'h0, r[15:8]}, {1'b1, 32'h0});
    for (int i = 4; i < 8; i++) begin
      wr(i[5:0], 4'hf, 32'hffffffff);
      rc(i[5:0], (i == 4 || i == 7) ? 32'h0000fff9 : 32'h0000fffd);
      wr(i[5:0], 4'h3, (i - 3) << 12);
    end
    wr(6'h02, 4'hf, 32'hffffffff);
    rc(6'h02, 32'h01018f00);
    chk({31'h0, io_out.native}, 33'h3);
    @(posedge sys_clk) io_space_enable <= 1'b1;
    ic(16'h1007, 6'b100001);
    ic(16'h1008, 6'b100000);
    ic(16'h2003, 6'b101000);
    ic(16'h3003, 6'b100010);
    ic(16'h3004, 6'b100000);
    ic(16'h4007, 6'b100100);
    wr(6'h02, 4'h2, 32'h0);
    chk({31'h0, io_out.native}, 33'h0);
    ic(16'h1000, 6'b100000);
    ic(16'h2000, 6'b100000);
    ic(16'h01f3, 6'b100001);
    ic(16'h0374, 6'b101000);
    @(posedge sys_clk) io_space_enable <= 1'b0;
    ic(16'h01f3, 6'b110000);
    @(posedge sys_clk) bm_io_hit <= 1'b1;
    ic(16'h8000, 6'b110000);
    @(posedge sys_clk) bm_io_hit <= 1'b0;
    @(posedge sys_clk) master_abort_evt <= 1'b1;
    rc(6'h01, 32'h22800000);
    wr(6'h01, 4'h8, 32'h20000000);
    rc(6'h01, 32'h02800000);
    @(posedge sys_clk) target_abort_evt <= 1'b1;
    rc(6'h01, 32'h0a800000);
    wr(6'h01, 4'h8, 32'h08000000);
    rc(6'h01, 32'h02800000);
    @(posedge sys_clk) clk_en <= 1'b0;
    host.cfg(1'b1, 6'h02, 4'h2, 32'h00000500, r);
    chk({r[32], 32'h0}, 33'h0);
    @(posedge sys_clk) clk_en <= 1'b1;
    rc(6'h02, 32'h01018a00);
    results();
  end
endmodule // tb
`default_nettype wire

// file: rtl/ifch_bar.sv
// Purpose: One I/O base register with its window compare
// Assumes: Writes arrive on the low two byte lanes only
// Notes:   LOW_BIT sets window size: 3 gives 8 bytes, 2 gives 4
`timescale 1ns/1ps
`default_nettype none
`include "ifch_defines.svh"

module ifch_bar #(
  parameter int LOW_BIT = `IFCH_CMD_LOW
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        wr_sel,
  input  wire logic [1:0]  be_lo,
  input  wire logic [15:0] wdata_lo,
  input  wire logic [15:0] io_addr,
  input  wire logic        win_open,
  output logic      [31:0] rdata,
  output logic             hit
);

  localparam int BW = `IFCH_BAR_TOP - LOW_BIT + 1;

  logic [BW-1:0] base_q;
  logic [BW-1:0] base_d;
  logic [15:0]   merged;

  // Byte lanes merged so a single-byte write keeps the other half
  assign merged = {(be_lo[1] ? wdata_lo[15:8] : rdata[15:8]),
                   (be_lo[0] ? wdata_lo[7:0]  : rdata[7:0])};
  assign base_d = wr_sel ? merged[`IFCH_BAR_TOP:LOW_BIT] : base_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)       base_q <= '0;
    else if (clk_en) base_q <= base_d;
  end

  // Reserved bits zero, bit 0 fixed as I/O request
  assign rdata = {16'h0000, base_q, {(LOW_BIT-1){1'b0}}, 1'b1};

  assign hit = win_open && (io_addr[`IFCH_BAR_TOP:LOW_BIT] == base_q);

endmodule : ifch_bar
`default_nettype wire

// file: rtl/ifch_defines.svh
// Purpose: Constants for the IDE function configuration header bank
// Assumes: Byte offsets inside a 256-byte configuration space
// Notes:   Dword index of a register is its byte offset bits 7:2
`ifndef IFCH_DEFINES_SVH
`define IFCH_DEFINES_SVH

// Register byte offsets
`define IFCH_OFF_STS        8'h06
`define IFCH_OFF_REV        8'h08
`define IFCH_OFF_PI         8'h09
`define IFCH_OFF_SCC        8'h0a
`define IFCH_OFF_BCC        8'h0b
`define IFCH_OFF_MLT        8'h0d
`define IFCH_OFF_PCMD       8'h10
`define IFCH_OFF_SCNL       8'h14
`define IFCH_OFF_PCNL       8'h18
`define IFCH_OFF_SCMD       8'h1c

// Reset and fixed values
`define IFCH_STS_RST        16'h0280
`define IFCH_PI_RST         8'h8a
`define IFCH_SCC_VAL        8'h01
`define IFCH_BCC_VAL        8'h01
`define IFCH_MLT_VAL        8'h00
`define IFCH_REV_VAL        8'h00

// Status field positions
`define IFCH_STS_RMA        13
`define IFCH_STS_STA        11

// Programming interface field positions
`define IFCH_PI_PSEL        0
`define IFCH_PI_SSEL        2

// Base register layout
`define IFCH_BAR_TOP        15
`define IFCH_CMD_LOW        3
`define IFCH_CTL_LOW        2

// Legacy port windows
`define IFCH_LEG_PCMD       16'h01f0
`define IFCH_LEG_PCTL       16'h03f4
`define IFCH_LEG_SCMD       16'h0170
`define IFCH_LEG_SCTL       16'h0374

`endif

// file: rtl/ifch_pkg.sv
// Purpose: Types shared by the configuration header bank
// Assumes: Dword-wide configuration access with byte enables
// Notes:   Offsets and values live in ifch_defines.svh
package ifch_pkg;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ifch_cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } ifch_cfg_rsp_s;

  typedef struct packed {
    logic       done;
    logic [3:0] hit;
    logic [1:0] native;
    logic       refused;
  } ifch_io_rsp_s;

  typedef enum logic [0:0] {
    IFCH_LEGACY = 1'b0,
    IFCH_NATIVE = 1'b1
  } ifch_mode_e;

endpackage : ifch_pkg

// file: rtl/ifch_top.sv
// Purpose: Configuration header bank of an integrated IDE function
// Assumes: Host bridge gives one dword config access per request
// Notes:   I/O window decode registered; one answer per request
//
// Function
// - Master abort by the bus master engine sets a flag; write 1 clears.
// - Target abort ended by this function sets a flag; write 1 clears.
// - Fast back-to-back bit reads 1; status resets to 0280h.
// - Select timing field reads fixed 01 and does nothing.
// - Parity, system error, data parity, USER_DEFINABLE_FEATURES, 66 MHz bits read 0.
// - Eight-bit revision register is fixed and read-only.
// - Bus master support bit reads 1; interface register resets to 8Ah.
// - Interface register bits 6:4 read 0.
// - Both channel mode capability bits read 1.
// - Writable bit 2 picks secondary mode; 0 legacy default, 1 native.
// - Writable bit 0 picks primary mode; 0 legacy default, 1 native.
// - Sub class register reads 01h, an IDE controller.
// - Base class register reads 01h, mass storage.
// - Latency timer reads zero and ignores writes.
// - Command base field bits 15:3, eight-byte window, upper bits reserved.
// - Control base field bits 15:2, four-byte window, upper bits reserved.
// - Bit 0 of each base register reads 1 and is not writable.
// - Command window decodes only while its channel is native.
// - Control window decodes only while its channel is native.
// - With I/O space disabled every channel and bus master access is refused.
`timescale 1ns/1ps
`default_nettype none
`include "ifch_defines.svh"

module ifch_top
  import ifch_pkg::*;
#(
  parameter logic [7:0] REV_ID = `IFCH_REV_VAL
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  input  wire ifch_pkg::ifch_cfg_req_s cfg_in,
  output ifch_pkg::ifch_cfg_rsp_s      cfg_out,
  input  wire logic          io_space_enable,
  input  wire logic          master_abort_evt,
  input  wire logic          target_abort_evt,
  input  wire logic          io_req,
  input  wire logic [15:0]   io_addr,
  input  wire logic          bm_io_hit,
  output ifch_pkg::ifch_io_rsp_s       io_out
);

  import ifch_pkg::*;

  // Byte offsets of the mapped registers
  localparam logic [7:0] OFF_STS  = `IFCH_OFF_STS;
  localparam logic [7:0] OFF_REV  = `IFCH_OFF_REV;
  localparam logic [7:0] OFF_MLT  = `IFCH_OFF_MLT;
  localparam logic [7:0] OFF_PCMD = `IFCH_OFF_PCMD;
  localparam logic [7:0] OFF_PCNL = `IFCH_OFF_PCNL;
  localparam logic [7:0] OFF_SCMD = `IFCH_OFF_SCMD;
  localparam logic [7:0] OFF_SCNL = `IFCH_OFF_SCNL;

  localparam logic [5:0] DW_STS = OFF_STS[7:2];
  localparam logic [5:0] DW_CLS = OFF_REV[7:2];
  localparam logic [5:0] DW_MLT = OFF_MLT[7:2];

  // Entry order: primary command, primary control, secondary command, secondary control
  localparam logic [5:0] DW_BAR [4] = '{OFF_PCMD[7:2], OFF_PCNL[7:2],
                                        OFF_SCMD[7:2], OFF_SCNL[7:2]};
  localparam logic [15:0] LEG_BASE [4] = '{`IFCH_LEG_PCMD, `IFCH_LEG_PCTL,
                                           `IFCH_LEG_SCMD, `IFCH_LEG_SCTL};

  // Status flag state
  logic        rma_q;
  logic        rma_d;
  logic        sta_q;
  logic        sta_d;

  // Channel mode selects
  ifch_mode_e  pmode_q;
  ifch_mode_e  pmode_d;
  ifch_mode_e  smode_q;
  ifch_mode_e  smode_d;

  // Config answer state
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // I/O answer state
  logic        io_done_q;
  logic [3:0]  io_hit_q;
  logic [3:0]  io_hit_d;
  logic        io_ref_q;
  logic        io_ref_d;

  // Decode wires
  logic        cfg_take;
  logic        cfg_wr;
  logic        sel_sts;
  logic        sel_cls;
  logic        sel_mlt;
  logic [3:0]  sel_bar;
  logic [31:0] bar_rdata [4];
  logic [3:0]  nat_hit;
  logic [3:0]  leg_hit;
  logic [1:0]  native;
  logic [3:0]  raw_hit;

  // Read images
  logic [15:0] sts_img;
  logic [7:0]  pi_img;
  logic [31:0] dw_sts_img;
  logic [31:0] dw_cls_img;
  logic [31:0] dw_mlt_img;
  logic [31:0] bar_mux;

  // Write strobes for write-one-to-clear and the mode select write
  logic        clr_rma;
  logic        clr_sta;
  logic        wr_pi;

  assign cfg_take = cfg_in.req && clk_en;
  assign cfg_wr   = cfg_take && cfg_in.wr;
  assign sel_sts  = (cfg_in.dw == DW_STS);
  assign sel_cls  = (cfg_in.dw == DW_CLS);
  assign sel_mlt  = (cfg_in.dw == DW_MLT);

  // Status sits in the upper half of its dword
  assign clr_rma = cfg_wr && sel_sts && cfg_in.be[3] && cfg_in.wdata[16 + `IFCH_STS_RMA];
  assign clr_sta = cfg_wr && sel_sts && cfg_in.be[3] && cfg_in.wdata[16 + `IFCH_STS_STA];

  // Set wins over clear, so an abort in the clearing cycle stays visible
  assign rma_d = master_abort_evt ? 1'b1 : (clr_rma ? 1'b0 : rma_q);
  assign sta_d = target_abort_evt ? 1'b1 : (clr_sta ? 1'b0 : sta_q);

  // Interface register is byte 1 of the class dword
  assign wr_pi   = cfg_wr && sel_cls && cfg_in.be[1];
  assign pmode_d = wr_pi ? ifch_mode_e'(cfg_in.wdata[8 + `IFCH_PI_PSEL]) : pmode_q;
  assign smode_d = wr_pi ? ifch_mode_e'(cfg_in.wdata[8 + `IFCH_PI_SSEL]) : smode_q;

  assign native = {smode_q == IFCH_NATIVE, pmode_q == IFCH_NATIVE};

  // Fixed bits come from the reset image, only flags vary
  assign sts_img = `IFCH_STS_RST
                 | (16'(rma_q) << `IFCH_STS_RMA)
                 | (16'(sta_q) << `IFCH_STS_STA);

  // Mode select bits are zero in the reset image
  assign pi_img = `IFCH_PI_RST
                | (8'(pmode_q) << `IFCH_PI_PSEL)
                | (8'(smode_q) << `IFCH_PI_SSEL);

  // Command half reads zero here; it lives elsewhere
  assign dw_sts_img = {sts_img, 16'h0000};
  assign dw_cls_img = {`IFCH_BCC_VAL, `IFCH_SCC_VAL, pi_img, REV_ID};
  assign dw_mlt_img = {16'h0000, `IFCH_MLT_VAL, 8'h00};

  // Base registers, one entry per window
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bar
      localparam int LOW = (gi % 2 == 0) ? `IFCH_CMD_LOW : `IFCH_CTL_LOW;
      localparam logic [15:0] LEG_MASK = ~((16'h0001 << LOW) - 16'h0001);
      logic win_open;

      assign sel_bar[gi] = (cfg_in.dw == DW_BAR[gi]);
      // Native windows need both the channel mode and I/O space enable
      assign win_open = native[gi/2] && io_space_enable;

      ifch_bar #(
        .LOW_BIT (LOW)
      ) u_bar (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .wr_sel   (cfg_wr && sel_bar[gi]),
        .be_lo    (cfg_in.be[1:0]),
        .wdata_lo (cfg_in.wdata[15:0]),
        .io_addr  (io_addr),
        .win_open (win_open),
        .rdata    (bar_rdata[gi]),
        .hit      (nat_hit[gi])
      );

      // Legacy ports answer only while the channel stays in legacy mode
      assign leg_hit[gi] = !native[gi/2] && io_space_enable
                         && ((io_addr & LEG_MASK) == LEG_BASE[gi]);

      // Would-be claim with I/O space ignored, only used to flag a refusal
      assign raw_hit[gi] = native[gi/2]
                         ? ((io_addr & LEG_MASK) == (bar_rdata[gi][15:0] & LEG_MASK))
                         : ((io_addr & LEG_MASK) == LEG_BASE[gi]);
    end
  endgenerate

  assign bar_mux = sel_bar[0] ? bar_rdata[0] :
                   sel_bar[1] ? bar_rdata[1] :
                   sel_bar[2] ? bar_rdata[2] :
                   sel_bar[3] ? bar_rdata[3] : 32'h0000_0000;

  // Unmapped dwords read zero
  assign rdata_d = cfg_in.wr ? 32'h0000_0000 :
                   sel_sts   ? dw_sts_img :
                   sel_cls   ? dw_cls_img :
                   sel_mlt   ? dw_mlt_img : bar_mux;

  // Any decoded channel access
  assign io_hit_d = nat_hit | leg_hit;

  // Refusal flagged for channel or bus master ports while I/O space is off
  assign io_ref_d = !io_space_enable && (bm_io_hit || (|raw_hit));

  // Flags and modes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rma_q   <= 1'b0;
      sta_q   <= 1'b0;
      pmode_q <= IFCH_LEGACY;
      smode_q <= IFCH_LEGACY;
    end else if (clk_en) begin
      rma_q   <= rma_d;
      sta_q   <= sta_d;
      pmode_q <= pmode_d;
      smode_q <= smode_d;
    end
  end

  // Config answer one cycle after the request
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_q   <= cfg_in.req;
      rdata_q <= cfg_in.req ? rdata_d : rdata_q;
    end
  end

  // I/O decode answer one cycle after the request
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_done_q <= 1'b0;
      io_hit_q  <= 4'h0;
      io_ref_q  <= 1'b0;
    end else if (clk_en) begin
      io_done_q <= io_req;
      io_hit_q  <= io_req ? io_hit_d : 4'h0;
      io_ref_q  <= io_req && io_ref_d;
    end
  end

  // Held low during reset, ack and done forced low while the clock enable is off
  assign cfg_out.ack    = ack_q && clk_en;
  assign cfg_out.rdata  = rdata_q;
  assign io_out.done    = io_done_q && clk_en;
  assign io_out.hit     = io_hit_q;
  assign io_out.native  = native;
  assign io_out.refused = io_ref_q;

endmodule : ifch_top
`default_nettype wire
